// *** pcf_pkg.sv ***
// Constants, types and register map for the data path configuration controller.
// Assumes a single 50 MHz management clock shared by all users of the package.
package pcf_pkg;
  localparam int PCF_LANES = 8;
  localparam int PCF_PATHS = 2;
  // Lane assignment of each path, fixed at build time
  localparam int PCF_HOST_FIRST [PCF_PATHS] = '{0, 4};
  localparam int PCF_HOST_COUNT [PCF_PATHS] = '{4, 4};
  localparam int PCF_MEDIA_FIRST [PCF_PATHS] = '{0, 4};
  localparam int PCF_MEDIA_COUNT [PCF_PATHS] = '{4, 4};

  // Module state codes seen on the module_state input
  localparam logic [2:0] PCF_MOD_STARTUP = 3'h1;
  localparam logic [2:0] PCF_MOD_UP = 3'h3;

  // Register byte offsets
  localparam logic [7:0] PCF_OFS_CTRL = 8'h00;
  localparam logic [7:0] PCF_OFS_TEARDOWN = 8'h04;
  localparam logic [7:0] PCF_OFS_TX_OFF = 8'h08;
  localparam logic [7:0] PCF_OFS_TX_QUIET = 8'h0C;
  localparam logic [7:0] PCF_OFS_APPLY = 8'h10;
  localparam logic [7:0] PCF_OFS_PENDING = 8'h14;
  localparam logic [7:0] PCF_OFS_STATE = 8'h18;
  localparam logic [7:0] PCF_OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] PCF_OFS_IRQ_MASK = 8'h20;

  // Field positions and reset values
  localparam int PCF_CTRL_LOWPWR_BIT = 0;
  localparam int PCF_CTRL_STEPWISE_BIT = 1;
  localparam int PCF_APPLY_NOW_BIT = 8;
  localparam int PCF_STATE_FIELD_W = 4;
  localparam logic [PCF_LANES-1:0] PCF_TEARDOWN_RST = 8'hFF;
  localparam logic [PCF_LANES-1:0] PCF_LANES_RST = 8'h00;
  localparam logic [PCF_PATHS-1:0] PCF_PATHS_RST = 2'h0;

  localparam logic [1:0] PCF_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCF_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    st_path_idle = 3'h1,
    st_path_initializing = 3'h2,
    st_path_initialized = 3'h3,
    st_path_tearing_down = 3'h4,
    st_tx_turning_on = 3'h5,
    st_path_active = 3'h6,
    st_tx_turning_off = 3'h7
  } pcf_state_e;

  // Completion reports from one path's resources
  typedef struct packed {
    logic init_done;
    logic deinit_done;
    logic tx_on_done;
    logic tx_off_done;
  } pcf_done_s;

  // Per-lane host controls feeding every machine
  typedef struct packed {
    logic [PCF_LANES-1:0] lane_teardown_bit;
    logic [PCF_LANES-1:0] lane_reinit_pending;
    logic [PCF_LANES-1:0] tx_output_off_bit;
    logic [PCF_LANES-1:0] tx_force_quiet_bit;
  } pcf_lanes_s;
endpackage : pcf_pkg

// *** pcf_path_fsm.sv ***
// One data path configuration state machine and its transition conditions.
// Assumes all inputs are synchronous to clk and rst_n is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module pcf_path_fsm
  import pcf_pkg::*;
#(
  parameter int HOST_FIRST = 0,
  parameter int HOST_COUNT = 4,
  parameter int MEDIA_FIRST = 0,
  parameter int MEDIA_COUNT = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] module_state,
  input wire logic module_reset_cond,
  input wire logic low_power_request,
  input wire logic stepwise_reconfig_only,
  input wire pcf_lanes_s lanes,
  input wire pcf_done_s done,
  output pcf_state_e state,
  output logic [PCF_LANES-1:0] pending_clear,
  output logic state_changed
);
  localparam logic [PCF_LANES-1:0] HOST_MASK =
    PCF_LANES'(((1 << HOST_COUNT) - 1) << HOST_FIRST);

  logic module_up_term;
  logic lane_teardown_any;
  logic pending_reinit_any;
  logic tx_disable_any;
  logic tx_squelch_any;
  logic path_teardown_cond;
  logic path_reteardown_cond;
  logic path_deactivate_cond;
  logic discard;
  pcf_state_e state_next;

  // Lane terms cover only this path's own lanes
  assign lane_teardown_any = |lanes.lane_teardown_bit[HOST_FIRST +: HOST_COUNT];
  assign pending_reinit_any = |lanes.lane_reinit_pending[HOST_FIRST +: HOST_COUNT];
  assign tx_disable_any = |lanes.tx_output_off_bit[MEDIA_FIRST +: MEDIA_COUNT];
  assign tx_squelch_any = |lanes.tx_force_quiet_bit[MEDIA_FIRST +: MEDIA_COUNT];

  // Transition conditions
  assign module_up_term = (module_state == PCF_MOD_UP);
  assign path_teardown_cond = !module_up_term || low_power_request || lane_teardown_any;
  assign path_reteardown_cond = stepwise_reconfig_only ? path_teardown_cond
                                : (path_teardown_cond || pending_reinit_any);
  assign path_deactivate_cond = path_reteardown_cond || tx_disable_any || tx_squelch_any;

  // Reset of the module or its startup phase forces the machine idle
  assign discard = module_reset_cond || (module_state == PCF_MOD_STARTUP);

  // Next state; steady states wait on their named conditions only
  always_comb begin
    state_next = state;
    case (state)
      st_path_idle: begin
        if (!path_teardown_cond) state_next = st_path_initializing;
      end
      st_path_initializing: begin
        if (path_teardown_cond) state_next = st_path_tearing_down;
        else if (done.init_done) state_next = st_path_initialized;
      end
      st_path_initialized: begin
        if (path_reteardown_cond) state_next = st_path_tearing_down;
        else if (!path_deactivate_cond) state_next = st_tx_turning_on;
      end
      st_path_tearing_down: begin
        if (done.deinit_done) state_next = st_path_idle;
      end
      st_tx_turning_on: begin
        if (path_deactivate_cond) state_next = st_tx_turning_off;
        else if (done.tx_on_done) state_next = st_path_active;
      end
      st_path_active: begin
        if (path_deactivate_cond) state_next = st_tx_turning_off;
      end
      st_tx_turning_off: begin
        if (done.tx_off_done) state_next = st_path_initialized;
      end
      default: state_next = st_path_idle;
    endcase
    if (discard) state_next = st_path_idle;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_path_idle;
      state_changed <= 1'b0;
    end else begin
      state <= state_next;
      state_changed <= (state_next != state);
    end
  end

  // Pending bits of own lanes clear while initializing
  assign pending_clear = (state == st_path_initializing) ? HOST_MASK : PCF_LANES_RST;

  sequence s_ready_to_turn_on;
    state == st_path_initialized && !path_deactivate_cond && !discard;
  endsequence
  sequence s_turning_on;
    state == st_tx_turning_on;
  endsequence

  a_idle_leaves_up: assert property (@(posedge clk) disable iff (!rst_n)
    state == st_path_idle && !path_teardown_cond && !discard |=> state == st_path_initializing)
    else $error("idle did not move to initializing");
  a_turn_on_step: assert property (@(posedge clk) disable iff (!rst_n)
    s_ready_to_turn_on |=> s_turning_on)
    else $error("initialized did not start turn-on");
  a_lane_off_path: assert property (@(posedge clk) disable iff (!rst_n)
    state == st_path_active && (tx_disable_any || tx_squelch_any) && !discard
    |=> state == st_tx_turning_off)
    else $error("single lane off did not turn path off");
  a_discard_idle: assert property (@(posedge clk) disable iff (!rst_n)
    module_reset_cond |=> state == st_path_idle)
    else $error("module reset did not discard machine");
  a_startup_idle: assert property (@(posedge clk) disable iff (!rst_n)
    module_state == PCF_MOD_STARTUP ##1 module_state == PCF_MOD_STARTUP
    |-> state == st_path_idle)
    else $error("machine not idle during startup");
  a_stepwise_same: assert property (@(posedge clk) disable iff (!rst_n)
    stepwise_reconfig_only && state == st_path_initialized && pending_reinit_any
    && !path_deactivate_cond && !discard |=> state == st_tx_turning_on)
    else $error("pending reinit acted under stepwise-only");
  a_pending_tear: assert property (@(posedge clk) disable iff (!rst_n)
    !stepwise_reconfig_only && state == st_path_initialized && pending_reinit_any
    && !discard |=> state == st_path_tearing_down)
    else $error("pending reinit did not tear down");
  a_steady_holds: assert property (@(posedge clk) disable iff (!rst_n)
    state == st_path_active && !path_deactivate_cond && !discard |=> $stable(state))
    else $error("active left without cause");
  a_teardown_wait: assert property (@(posedge clk) disable iff (!rst_n)
    state == st_path_tearing_down && !done.deinit_done && !discard
    |=> state == st_path_tearing_down)
    else $error("teardown left before completion");
endmodule : pcf_path_fsm
`default_nettype wire

// *** pcf_top.sv ***
// Data path configuration controller: AXI4-Lite registers, pending-reinit
// bookkeeping, one state machine per path and a level interrupt.
// Assumes module state, reset condition and completion reports come from
// logic on clk; only rst_n is asynchronous.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcf_top
  import pcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] module_state,
  input wire logic module_reset_cond,
  input wire logic stepwise_reconfig_only,
  input wire pcf_done_s [PCF_PATHS-1:0] path_done,
  output pcf_state_e [PCF_PATHS-1:0] path_state,
  output logic [PCF_PATHS-1:0] path_active,
  output logic apply_now_pulse,
  output logic irq
);
  logic rst_meta_n;
  logic rst_sync_n;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_fire;
  logic wr_hit;
  logic rd_fire;
  logic low_power_reg;
  logic [PCF_LANES-1:0] teardown_reg;
  logic [PCF_LANES-1:0] tx_off_reg;
  logic [PCF_LANES-1:0] tx_quiet_reg;
  logic [PCF_LANES-1:0] pending_reg;
  logic [PCF_LANES-1:0] pending_set;
  logic [PCF_LANES-1:0] pending_clr_all;
  logic [PCF_LANES-1:0] pending_clr [PCF_PATHS];
  logic [PCF_PATHS-1:0] irq_status_reg;
  logic [PCF_PATHS-1:0] irq_mask_reg;
  logic [PCF_PATHS-1:0] irq_clear;
  logic [PCF_PATHS-1:0] path_event;
  logic apply_now_reg;
  logic [31:0] state_word;
  logic [31:0] rd_value;
  logic rd_hit;
  pcf_lanes_s lanes;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Write channels are taken independently, held until both are in
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Decode of writable offsets
  always_comb begin
    case (awaddr_reg)
      PCF_OFS_CTRL, PCF_OFS_TEARDOWN, PCF_OFS_TX_OFF, PCF_OFS_TX_QUIET,
      PCF_OFS_APPLY, PCF_OFS_IRQ_STATUS, PCF_OFS_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response one cycle after both channels are in
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= PCF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Host control registers; only the low byte holds lane bits
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_power_reg <= 1'b0;
      teardown_reg <= PCF_TEARDOWN_RST;
      tx_off_reg <= PCF_LANES_RST;
      tx_quiet_reg <= PCF_LANES_RST;
      irq_mask_reg <= PCF_PATHS_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (awaddr_reg)
        PCF_OFS_CTRL: low_power_reg <= wdata_reg[PCF_CTRL_LOWPWR_BIT];
        PCF_OFS_TEARDOWN: teardown_reg <= wdata_reg[PCF_LANES-1:0];
        PCF_OFS_TX_OFF: tx_off_reg <= wdata_reg[PCF_LANES-1:0];
        PCF_OFS_TX_QUIET: tx_quiet_reg <= wdata_reg[PCF_LANES-1:0];
        PCF_OFS_IRQ_MASK: irq_mask_reg <= wdata_reg[PCF_PATHS-1:0];
        default: ;
      endcase
    end
  end

  // Apply triggers: low byte picks reinit lanes, a separate bit applies now
  assign pending_set = (wr_fire && wstrb_reg[0] && awaddr_reg == PCF_OFS_APPLY)
                       ? wdata_reg[PCF_LANES-1:0] : PCF_LANES_RST;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      apply_now_reg <= 1'b0;
    end else begin
      apply_now_reg <= wr_fire && wstrb_reg[1] && awaddr_reg == PCF_OFS_APPLY
                       && wdata_reg[PCF_APPLY_NOW_BIT];
    end
  end
  assign apply_now_pulse = apply_now_reg;

  // Pending bits: all triggered lanes set together; a set beats a clear
  always_comb begin
    pending_clr_all = PCF_LANES_RST;
    for (int p = 0; p < PCF_PATHS; p++) begin
      pending_clr_all = pending_clr_all | pending_clr[p];
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pending_reg <= PCF_LANES_RST;
    end else begin
      pending_reg <= (pending_reg & ~pending_clr_all) | pending_set;
    end
  end

  assign lanes.lane_teardown_bit = teardown_reg;
  assign lanes.lane_reinit_pending = pending_reg;
  assign lanes.tx_output_off_bit = tx_off_reg;
  assign lanes.tx_force_quiet_bit = tx_quiet_reg;

  // One machine per path, each over its own lanes
  generate
    for (genvar g = 0; g < PCF_PATHS; g++) begin : g_path
      pcf_path_fsm #(
        .HOST_FIRST(PCF_HOST_FIRST[g]),
        .HOST_COUNT(PCF_HOST_COUNT[g]),
        .MEDIA_FIRST(PCF_MEDIA_FIRST[g]),
        .MEDIA_COUNT(PCF_MEDIA_COUNT[g])
      ) u_fsm (
        .clk(clk),
        .rst_n(rst_sync_n),
        .module_state(module_state),
        .module_reset_cond(module_reset_cond),
        .low_power_request(low_power_reg),
        .stepwise_reconfig_only(stepwise_reconfig_only),
        .lanes(lanes),
        .done(path_done[g]),
        .state(path_state[g]),
        .pending_clear(pending_clr[g]),
        .state_changed(path_event[g])
      );
      // Partly lit paths count as not activated
      assign path_active[g] = (path_state[g] == st_path_active);
      assign state_word[g*PCF_STATE_FIELD_W +: PCF_STATE_FIELD_W] = {1'b0, path_state[g]};
    end
  endgenerate
  assign state_word[31:PCF_PATHS*PCF_STATE_FIELD_W] = '0;

  // Sticky state-change flags; a new event wins over a write-one clear
  assign irq_clear = (wr_fire && wstrb_reg[0] && awaddr_reg == PCF_OFS_IRQ_STATUS)
                     ? wdata_reg[PCF_PATHS-1:0] : PCF_PATHS_RST;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status_reg <= PCF_PATHS_RST;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | path_event;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read mux; unmapped offsets read zero with an error response
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      PCF_OFS_CTRL: begin
        rd_value[PCF_CTRL_LOWPWR_BIT] = low_power_reg;
        rd_value[PCF_CTRL_STEPWISE_BIT] = stepwise_reconfig_only;
      end
      PCF_OFS_TEARDOWN: rd_value[PCF_LANES-1:0] = teardown_reg;
      PCF_OFS_TX_OFF: rd_value[PCF_LANES-1:0] = tx_off_reg;
      PCF_OFS_TX_QUIET: rd_value[PCF_LANES-1:0] = tx_quiet_reg;
      PCF_OFS_APPLY: rd_value = 32'h0000_0000;
      PCF_OFS_PENDING: rd_value[PCF_LANES-1:0] = pending_reg;
      PCF_OFS_STATE: rd_value = state_word;
      PCF_OFS_IRQ_STATUS: rd_value[PCF_PATHS-1:0] = irq_status_reg;
      PCF_OFS_IRQ_MASK: rd_value[PCF_PATHS-1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data registered one cycle after the address is taken
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= PCF_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
      rdata_reg <= rd_value;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  a_pending_set: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pending_set != PCF_LANES_RST |=> (pending_reg & $past(pending_set)) == $past(pending_set))
    else $error("triggered lanes not all marked pending");
  a_pending_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    path_state[0] == st_path_initializing && pending_set == PCF_LANES_RST
    |=> (pending_reg & pending_clr[0]) == PCF_LANES_RST || pending_clr[0] == PCF_LANES_RST)
    else $error("pending bits kept while initializing");
  a_apply_now_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    apply_now_reg && $past(pending_clr_all) == PCF_LANES_RST
    && $past(pending_set) == PCF_LANES_RST
    |-> pending_reg == $past(pending_reg))
    else $error("apply-now altered pending bits");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_n)
    path_event[0] && irq_mask_reg[0] ##1 irq_mask_reg[0] |-> irq)
    else $error("masked-in event raised no interrupt");
endmodule : pcf_top
`default_nettype wire

// *** pcf_res_model.sv ***
// Path resource model: reports completion of the current transient step.
// Assumes path_state is registered on clk; reports drop on leaving a state.
`timescale 1ns/1ps
`default_nettype none
module pcf_res_model
  import pcf_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire pcf_state_e [PCF_PATHS-1:0] path_state,
  output pcf_done_s [PCF_PATHS-1:0] path_done
);
  pcf_state_e last_reg [PCF_PATHS] = '{default: st_path_idle};
  logic [3:0] age_reg [PCF_PATHS] = '{default: 4'h0};
  // Age restarts on each change, so every step waits its own delay
  always @(posedge clk) begin
    for (int p = 0; p < PCF_PATHS; p++) begin
      last_reg[p] <= path_state[p];
      if (path_state[p] != last_reg[p]) begin
        age_reg[p] <= 4'h0;
      end else if (age_reg[p] != 4'hF) begin
        age_reg[p] <= age_reg[p] + 4'h1;
      end
    end
  end
  // Reports are levels, only inside their own state; slow mode stalls them
  always_comb begin
    for (int p = 0; p < PCF_PATHS; p++) begin
      logic ok;
      ok = (path_state[p] == last_reg[p]) && (age_reg[p] >= (slow ? 4'h8 : 4'h1));
      path_done[p].init_done = ok && (path_state[p] == st_path_initializing);
      path_done[p].deinit_done = ok && (path_state[p] == st_path_tearing_down);
      path_done[p].tx_on_done = ok && (path_state[p] == st_tx_turning_on);
      path_done[p].tx_off_done = ok && (path_state[p] == st_tx_turning_off);
    end
  end
endmodule : pcf_res_model
`default_nettype wire

// *** pcf_top_tb_top.sv ***
// Self-checking bench: register tasks over AXI4-Lite, path walks, interrupt.
// Assumes the resource model answers completion reports on clk.
`timescale 1ns/1ps
`default_nettype none
module pcf_top_tb_top
  import pcf_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, stepwise_reconfig_only = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] module_state = PCF_MOD_UP;
  logic module_reset_cond = 1'h0, slow = 1'h0, irq, apply_now_pulse;
  pcf_done_s [PCF_PATHS-1:0] path_done;
  pcf_state_e [PCF_PATHS-1:0] path_state;
  logic [PCF_PATHS-1:0] path_active;
  int mismatches = 0, check_count = 0, pulses = 0;
  always #10 clk = ~clk;
  pcf_top pcf_top_inst (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .module_state, .module_reset_cond,
    .stepwise_reconfig_only, .path_done, .path_state, .path_active, .apply_now_pulse, .irq);
  pcf_res_model pcf_res_model_inst (.clk, .slow, .path_state, .path_done);
  // Counts apply-now pulses seen at the clock edge
  always @(posedge clk) if (apply_now_pulse === 1'h1) pulses++;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  // Bounded wait; path walks take a handful of cycles per step
  task automatic wait_st(input int p, input pcf_state_e s);
    int n;
    n = 0;
    while (path_state[p] !== s && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("path state", 32'(s), 32'(path_state[p]));
  endtask : wait_st
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(20 * 20000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    rd(PCF_OFS_TEARDOWN);
    chk("teardown reset", 32'hFF, v);
    rd(PCF_OFS_STATE);
    chk("state reset", 32'h11, v);
    rd(8'h40);
    chk("unmapped read", 32'(PCF_RESP_SLVERR), 32'(resp));
    wr(8'h44, 32'h1);
    chk("unmapped write", 32'(PCF_RESP_SLVERR), 32'(resp));
    wr(PCF_OFS_TEARDOWN, 32'hF0);
    wait_st(0, st_path_active);
    chk("other path", 32'(st_path_idle), 32'(path_state[1]));
    wr(PCF_OFS_TX_OFF, 32'h10);
    repeat (10) @(posedge clk);
    chk("foreign lane", 32'h1, 32'(path_active[0]));
    // One disabled, then one squelched, media lane takes the path down
    for (int i = 0; i < 2; i++) begin
      wr(i ? PCF_OFS_TX_QUIET : PCF_OFS_TX_OFF, 32'h8);
      wait_st(0, st_path_initialized);
      chk("path active", 32'h0, 32'(path_active[0]));
      wr(i ? PCF_OFS_TX_QUIET : PCF_OFS_TX_OFF, 32'h0);
      wait_st(0, st_path_active);
    end
    wr(PCF_OFS_APPLY, 32'h100);
    rd(PCF_OFS_PENDING);
    chk("pending after apply now", 32'h0, v);
    chk("apply now pulses", 32'h1, 32'(pulses));
    wr(PCF_OFS_APPLY, 32'h0F);
    rd(PCF_OFS_PENDING);
    chk("pending set", 32'h0F, v);
    repeat (10) @(posedge clk);
    chk("stepwise holds", 32'(st_path_active), 32'(path_state[0]));
    // Turn-off and back with reinit pending: stepwise-only ignores it
    wr(PCF_OFS_TX_QUIET, 32'h1);
    wait_st(0, st_path_initialized);
    wr(PCF_OFS_TX_QUIET, 32'h0);
    wait_st(0, st_path_active);
    wr(PCF_OFS_APPLY, 32'h100);
    rd(PCF_OFS_PENDING);
    chk("pending kept by apply now", 32'h0F, v);
    chk("apply now pulses again", 32'h2, 32'(pulses));
    slow <= 1'h1;
    stepwise_reconfig_only <= 1'h0;
    wait_st(0, st_path_tearing_down);
    wait_st(0, st_path_initializing);
    rd(PCF_OFS_PENDING);
    chk("pending cleared", 32'h0, v);
    wait_st(0, st_path_active);
    slow <= 1'h0;
    wr(PCF_OFS_CTRL, 32'h1);
    wait_st(0, st_path_idle);
    wr(PCF_OFS_CTRL, 32'h0);
    wait_st(0, st_path_active);
    wr(PCF_OFS_TEARDOWN, 32'hF2);
    wait_st(0, st_path_idle);
    wr(PCF_OFS_TEARDOWN, 32'hF0);
    wait_st(0, st_path_active);
    module_reset_cond <= 1'h1;
    wait_st(0, st_path_idle);
    module_reset_cond <= 1'h0;
    module_state <= PCF_MOD_STARTUP;
    repeat (8) @(posedge clk);
    chk("startup holds idle", 32'(st_path_idle), 32'(path_state[0]));
    module_state <= PCF_MOD_UP;
    wait_st(0, st_path_active);
    // Interrupt: masked event stays quiet, unmasking raises, W1C lowers
    wr(PCF_OFS_IRQ_STATUS, 32'h3);
    wr(PCF_OFS_TX_OFF, 32'h1);
    wait_st(0, st_path_initialized);
    chk("irq masked", 32'h0, 32'(irq));
    rd(PCF_OFS_IRQ_STATUS);
    chk("status sticky", 32'h1, v & 32'h1);
    wr(PCF_OFS_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, 32'(irq));
    wr(PCF_OFS_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    tally_and_finish();
  end
endmodule : pcf_top_tb_top
`default_nettype wire
